/* rtl/dqps_top.sv */
/*
  Strobe phase-shift loop block: two delay loops, phase offsets, per-pin
  setting registers and an AHB-Lite register slave.
  Assumes hready is the one slave's hreadyout, phase comparator outputs and the
  reset pin arrive asynchronously, and the per-pin chains sit outside.
*/
// Implementation choices: the placing of the registers and register access over AHB-Lite.
// Operation
// - Delay word is Gray coded.
// - Low jitter lock within 1280 cycles.
// - Standard mode locks in 256 cycles.
// - Two loops, two offset outputs each.
// - Same delay word to every side.
// - Each pin picks a loop output.
// - Reference from PLL or loop pins.
// - Chain up to sixteen elements compared.
// - Up/down steps the 6-bit counter.
// - Offsets only to pins; delay to core.
// - Pin or core reset forces relock.
// - Six modes set chain length.
// - Short modes hold delay msb zero.
// - Zero shift bypasses loop and chain.
// - Shifted strobe may route to core.
// - Complement echo route for QDR only.
// - All pins update on one tick.
// - Offset Gray two's complement, clamped range.
// - Settings registered under update enable.
module dqps_top
  import dqps_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic loop_rst_pin,
  input wire logic [NUM_LOOPS-1:0] phase_upndn,
  output logic [NUM_LOOPS-1:0][SEL_W-1:0] loop_ref_sel,
  output logic [NUM_LOOPS-1:0][CHAIN_W-1:0] loop_chain_len,
  output wire logic [NUM_LOOPS-1:0] loop_locked,
  output wire logic [NUM_LOOPS-1:0][DLY_W-1:0] core_delay,
  output logic [NUM_LOOPS-1:0][NUM_SIDES-1:0][DLY_W-1:0] side_delay,
  output logic [NUM_STROBES-1:0][DLY_W-1:0] pin_delay,
  output logic [NUM_STROBES-1:0][OFS_W-1:0] pin_offset,
  output logic [NUM_STROBES-1:0] pin_bypass,
  output logic [NUM_STROBES-1:0] pin_core_route,
  output logic cqn_route_en
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic [NUM_LOOPS-1:0][MODE_W-1:0] mode;
    logic [NUM_LOOPS-1:0] lj;
    logic [NUM_LOOPS-1:0][SEL_W-1:0] refsel;
    logic [NUM_LOOPS-1:0] soft_rst;
    logic [NUM_OFS-1:0][OFS_W-1:0] ofs;
    logic [2*NUM_STROBES-1:0] pin_sel;
    logic [NUM_STROBES-1:0] byp;
    logic [NUM_STROBES-1:0] core_route;
    logic cqn_en;
    logic rst_s1;
    logic rst_s2;
    logic [NUM_LOOPS-1:0] ud_s1;
    logic [NUM_LOOPS-1:0] ud_s2;
    logic [1:0] upd_cnt;
    logic upd_tick;
    logic [NUM_LOOPS-1:0][NUM_SIDES-1:0][DLY_W-1:0] side_dly;
    logic [NUM_LOOPS-1:0][CHAIN_W-1:0] chain;
    logic [NUM_STROBES-1:0][DLY_W-1:0] pin_dly;
    logic [NUM_STROBES-1:0][OFS_W-1:0] pin_ofs;
    logic [NUM_STROBES-1:0] pin_byp;
    logic [NUM_STROBES-1:0] pin_core;
    logic cqn_o;
  } dqps_top_st_t;

  dqps_top_st_t s_r;
  dqps_top_st_t s_nxt;
  logic [NUM_OFS-1:0][OFS_W-1:0] eff_ofs;
  logic [NUM_STROBES-1:0][DLY_W-1:0] pin_dly_nxt;
  logic [NUM_STROBES-1:0][OFS_W-1:0] pin_ofs_nxt;
  logic [NUM_LOOPS-1:0] restart;
  logic take;

  // ==========================================================================
  // Loops
  // A held reset pin keeps both loops relocking until it is released.
  genvar l;
  generate
    for (l = 0; l < NUM_LOOPS; l++) begin : g_loop
      assign restart[l] = s_r.soft_rst[l] | s_r.rst_s2;
      dqps_loop u_loop (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(s_r.mode[l]),
        .low_jitter(s_r.lj[l]),
        .restart(restart[l]),
        .upndn(s_r.ud_s2[l]),
        .upd_tick(s_r.upd_tick),
        .delay_gray(core_delay[l]),
        .locked(loop_locked[l])
      );
    end
  endgenerate

  // ==========================================================================
  // Phase offsets
  // Each loop owns two offsets; short modes clamp them to -32..+31.
  genvar o;
  generate
    for (o = 0; o < NUM_OFS; o++) begin : g_ofs
      logic [OFS_W-1:0] ob;
      logic [OFS_W-1:0] oc;
      logic short_m;
      assign ob = dqps_gray2bin7(s_r.ofs[o]);
      assign short_m = dqps_mode_short(s_r.mode[o/2]);
      assign oc = (short_m && ($signed(ob) > $signed(OFS_MAX_SHORT))) ? OFS_MAX_SHORT :
                  (short_m && ($signed(ob) < $signed(OFS_MIN_SHORT))) ? OFS_MIN_SHORT : ob;
      assign eff_ofs[o] = dqps_bin2gray7(oc);
    end
  endgenerate

  // ==========================================================================
  // Per-pin setting selection
  // Two select bits per pin: loop, then which offset output of that loop.
  genvar p;
  generate
    for (p = 0; p < NUM_STROBES; p++) begin : g_pin
      logic lsel;
      logic osel;
      assign lsel = s_r.pin_sel[2*p];
      assign osel = s_r.pin_sel[2*p+1];
      assign pin_dly_nxt[p] = s_r.byp[p] ? 6'h00 : core_delay[lsel];
      assign pin_ofs_nxt[p] = s_r.byp[p] ? 7'h00 : eff_ofs[{lsel, osel}];
    end
  endgenerate

  // ==========================================================================
  // Next-state logic
  assign take = hsel && htrans[1] && hready;

  // Bus slave, register file, synchronisers and update enable.
  always_comb begin
    logic [31:0] rd_word;
    rd_word = 32'h0000_0000;
    s_nxt = s_r;
    s_nxt.soft_rst = '0;
    s_nxt.resp = 1'b0;

    // Two-flop synchronisers for the reset pin and comparator outputs.
    s_nxt.rst_s1 = loop_rst_pin;
    s_nxt.rst_s2 = s_r.rst_s1;
    s_nxt.ud_s1 = phase_upndn;
    s_nxt.ud_s2 = s_r.ud_s1;

    // Common update enable shared by every pin register.
    s_nxt.upd_cnt = s_r.upd_cnt + 2'h1;
    s_nxt.upd_tick = (s_r.upd_cnt == UPD_PERIOD_CYC);

    // Address phase; reads take one wait state so writes land first.
    if (take) begin
      s_nxt.wr_pend = hwrite;
      s_nxt.rd_pend = !hwrite;
      s_nxt.addr = haddr[7:0];
      s_nxt.ready = hwrite;
    end else begin
      s_nxt.wr_pend = 1'b0;
    end

    // Read mux; unmapped offsets read as zero.
    for (int i = 0; i < NUM_LOOPS; i++) begin
      if (s_r.addr == ADDR_CTRL[i]) begin
        rd_word[CTRL_MODE_LSB +: MODE_W] = s_r.mode[i];
        rd_word[CTRL_LJ_BIT] = s_r.lj[i];
        rd_word[CTRL_REF_LSB +: SEL_W] = s_r.refsel[i];
      end
      if (s_r.addr == ADDR_OFS[i]) begin
        rd_word[OFS_A_LSB +: OFS_W] = s_r.ofs[2*i];
        rd_word[OFS_B_LSB +: OFS_W] = s_r.ofs[2*i+1];
      end
    end
    if (s_r.addr == ADDR_STATUS) begin
      rd_word[ST_LOCK_LSB +: NUM_LOOPS] = loop_locked;
      rd_word[ST_DLY0_LSB +: DLY_W] = core_delay[0];
      rd_word[ST_DLY1_LSB +: DLY_W] = core_delay[1];
    end
    if (s_r.addr == ADDR_PINSEL) begin
      rd_word[2*NUM_STROBES-1:0] = s_r.pin_sel;
    end
    if (s_r.addr == ADDR_ROUTE) begin
      rd_word[ROUTE_BYP_LSB +: NUM_STROBES] = s_r.byp;
      rd_word[ROUTE_CORE_LSB +: NUM_STROBES] = s_r.core_route;
      rd_word[ROUTE_CQN_BIT] = s_r.cqn_en;
    end
    if (s_r.rd_pend) begin
      s_nxt.rdata = rd_word;
      s_nxt.ready = 1'b1;
      s_nxt.rd_pend = 1'b0;
    end

    // Data phase of a write.
    if (s_r.wr_pend) begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        if (s_r.addr == ADDR_CTRL[i]) begin
          // Mode or jitter changes restart the loop as well as the reset bit.
          if (hwdata[CTRL_MODE_LSB +: MODE_W] <= MODE_MAX) begin
            s_nxt.mode[i] = hwdata[CTRL_MODE_LSB +: MODE_W];
            if (hwdata[CTRL_MODE_LSB +: MODE_W] != s_r.mode[i]) begin
              s_nxt.soft_rst[i] = 1'b1;
            end
          end
          s_nxt.lj[i] = hwdata[CTRL_LJ_BIT];
          if (hwdata[CTRL_LJ_BIT] != s_r.lj[i]) begin
            s_nxt.soft_rst[i] = 1'b1;
          end
          if (hwdata[CTRL_REF_LSB +: SEL_W] <= REF_MAX[i]) begin
            s_nxt.refsel[i] = hwdata[CTRL_REF_LSB +: SEL_W];
          end else begin
            s_nxt.refsel[i] = REF_PLL;
          end
          if (hwdata[CTRL_RST_BIT]) begin
            s_nxt.soft_rst[i] = 1'b1;
          end
        end
        if (s_r.addr == ADDR_OFS[i]) begin
          s_nxt.ofs[2*i] = hwdata[OFS_A_LSB +: OFS_W];
          s_nxt.ofs[2*i+1] = hwdata[OFS_B_LSB +: OFS_W];
        end
      end
      if (s_r.addr == ADDR_PINSEL) begin
        s_nxt.pin_sel = hwdata[2*NUM_STROBES-1:0];
      end
      if (s_r.addr == ADDR_ROUTE) begin
        s_nxt.byp = hwdata[ROUTE_BYP_LSB +: NUM_STROBES];
        s_nxt.core_route = hwdata[ROUTE_CORE_LSB +: NUM_STROBES];
        s_nxt.cqn_en = hwdata[ROUTE_CQN_BIT];
      end
    end

    // Loop outputs fanned out identically to all sides, plus chain length.
    for (int i = 0; i < NUM_LOOPS; i++) begin
      s_nxt.side_dly[i] = {NUM_SIDES{core_delay[i]}};
      s_nxt.chain[i] = dqps_chain_len(s_r.mode[i]);
    end

    // Pin registers load together on the shared tick.
    if (s_r.upd_tick) begin
      s_nxt.pin_dly = pin_dly_nxt;
      s_nxt.pin_ofs = pin_ofs_nxt;
      s_nxt.pin_byp = s_r.byp;
      s_nxt.pin_core = s_r.core_route & ~s_r.byp;
      s_nxt.cqn_o = s_r.cqn_en;
    end
  end

  // ==========================================================================
  // State register
  // Reset leaves low jitter selected, mode 0, PLL reference, bus ready.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.ready <= 1'b1;
      s_r.lj <= {NUM_LOOPS{LJ_RST}};
      s_r.mode <= {NUM_LOOPS{MODE_RST}};
      s_r.refsel <= {NUM_LOOPS{REF_PLL}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs, each straight from a register.
  assign hrdata = s_r.rdata;
  assign hreadyout = s_r.ready;
  assign hresp = s_r.resp;
  assign loop_ref_sel = s_r.refsel;
  assign loop_chain_len = s_r.chain;
  assign side_delay = s_r.side_dly;
  assign pin_delay = s_r.pin_dly;
  assign pin_offset = s_r.pin_ofs;
  assign pin_bypass = s_r.pin_byp;
  assign pin_core_route = s_r.pin_core;
  assign cqn_route_en = s_r.cqn_o;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_pin_sync;
    (pin_delay != $past(pin_delay)) |-> $past(s_r.upd_tick);
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("pin delay moved off the tick");

  property p_bypass;
    pin_bypass[0] |-> (pin_delay[0] == 6'h00) && (pin_offset[0] == 7'h00) && !pin_core_route[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed pin carries a setting");

  property p_side_same;
    ##1 (side_delay[0][0] == side_delay[0][2]) && (side_delay[1][1] == $past(core_delay[1]));
  endproperty
  a_side_same: assert property (p_side_same) else $error("sides disagree on delay word");

  property p_ofs_short;
    s_r.upd_tick && dqps_mode_short(s_r.mode[0]) && dqps_mode_short(s_r.mode[1]) |=>
      ($signed(dqps_gray2bin7(pin_offset[0])) <= $signed(OFS_MAX_SHORT)) &&
      ($signed(dqps_gray2bin7(pin_offset[0])) >= $signed(OFS_MIN_SHORT));
  endproperty
  a_ofs_short: assert property (p_ofs_short) else $error("offset outside short range");

  property p_ref_range;
    (loop_ref_sel[0] <= REF_MAX[0]) && (loop_ref_sel[1] <= REF_MAX[1]);
  endproperty
  a_ref_range: assert property (p_ref_range) else $error("reference select out of range");

  property p_pin_reset;
    s_r.rst_s2 |=> (loop_locked == 2'h0);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("lock held during pin reset");

  c_read: cover property (s_r.rd_pend ##1 hreadyout);
  c_pin_update: cover property (s_r.upd_tick ##1 (pin_delay != $past(pin_delay)));
  c_bypass: cover property ($rose(pin_bypass[0]));

endmodule

/* rtl/dqps_pkg.sv */
/*
  Shared constants, types and helpers for the strobe phase-shift loop block.
  Assumes one clock domain (hclk) and a 32-bit AHB-Lite register port.
*/
package dqps_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_LOOPS = 2;
  localparam int NUM_OFS = 4;
  localparam int NUM_STROBES = 8;
  localparam int NUM_SIDES = 3;
  localparam int DLY_W = 6;
  localparam int OFS_W = 7;
  localparam int SEL_W = 4;
  localparam int LOCK_W = 11;
  localparam int MODE_W = 3;
  localparam int CHAIN_W = 5;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_OFS0 = 8'h08;
  localparam logic [7:0] ADDR_OFS1 = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_PINSEL = 8'h14;
  localparam logic [7:0] ADDR_ROUTE = 8'h18;
  localparam logic [NUM_LOOPS-1:0][7:0] ADDR_CTRL = {ADDR_CTRL1, ADDR_CTRL0};
  localparam logic [NUM_LOOPS-1:0][7:0] ADDR_OFS = {ADDR_OFS1, ADDR_OFS0};

  // ==========================================================================
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LJ_BIT = 3;
  localparam int CTRL_RST_BIT = 4;
  localparam int CTRL_REF_LSB = 8;
  localparam int OFS_A_LSB = 0;
  localparam int OFS_B_LSB = 8;
  localparam int ST_LOCK_LSB = 0;
  localparam int ST_DLY0_LSB = 8;
  localparam int ST_DLY1_LSB = 16;
  localparam int ROUTE_BYP_LSB = 0;
  localparam int ROUTE_CORE_LSB = 8;
  localparam int ROUTE_CQN_BIT = 16;

  // ==========================================================================
  // Reset values and limits
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
  localparam logic LJ_RST = 1'b1;
  localparam logic [SEL_W-1:0] REF_PLL = 4'h0;
  localparam logic [NUM_LOOPS-1:0][SEL_W-1:0] REF_MAX = {4'h8, 4'h4};
  localparam logic [MODE_W-1:0] MODE_MAX = 3'h5;
  localparam logic [MODE_W-1:0] MODE_SHORT_A = 3'h4;
  localparam logic [MODE_W-1:0] MODE_SHORT_B = 3'h5;
  localparam logic [DLY_W-1:0] DLY_MAX_FULL = 6'h3F;
  localparam logic [DLY_W-1:0] DLY_MAX_SHORT = 6'h1F;
  localparam logic [OFS_W-1:0] OFS_MAX_SHORT = 7'h1F;
  localparam logic [OFS_W-1:0] OFS_MIN_SHORT = 7'h60;

  // ==========================================================================
  // Timing counts in hclk cycles
  localparam logic [LOCK_W-1:0] LOCK_LJ_CYC = 11'h500;
  localparam logic [LOCK_W-1:0] LOCK_STD_CYC = 11'h100;
  localparam logic [1:0] UPD_PERIOD_CYC = 2'h3;

  // ==========================================================================
  // Loop state
  typedef enum logic {
    LS_LOCKING = 1'b0,
    LS_LOCKED = 1'b1
  } dqps_lstate_t;

  // ==========================================================================
  // Helpers
  function automatic logic [OFS_W-1:0] dqps_bin2gray7(input logic [OFS_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [DLY_W-1:0] dqps_bin2gray6(input logic [DLY_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [OFS_W-1:0] dqps_gray2bin7(input logic [OFS_W-1:0] g);
    logic [OFS_W-1:0] b;
    b[OFS_W-1] = g[OFS_W-1];
    for (int i = OFS_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic dqps_mode_short(input logic [MODE_W-1:0] m);
    return (m == MODE_SHORT_A) || (m == MODE_SHORT_B);
  endfunction

  function automatic logic [CHAIN_W-1:0] dqps_chain_len(input logic [MODE_W-1:0] m);
    case (m)
      3'h0: return 5'h10;
      3'h1, 3'h4: return 5'h0C;
      3'h2, 3'h5: return 5'h0A;
      3'h3: return 5'h08;
      default: return 5'h10;
    endcase
  endfunction

endpackage

/* rtl/dqps_loop.sv */
/*
  One delay loop: lock timer and Gray-coded up/down delay setting counter.
  Assumes the up/down direction is already synchronised to hclk and that the
  update tick is a one-cycle pulse from the same clock.
*/
module dqps_loop
  import dqps_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [MODE_W-1:0] mode,
  input wire logic low_jitter,
  input wire logic restart,
  input wire logic upndn,
  input wire logic upd_tick,
  output logic [DLY_W-1:0] delay_gray,
  output logic locked
);

  typedef struct packed {
    dqps_lstate_t st;
    logic [LOCK_W-1:0] cnt;
    logic [DLY_W-1:0] bin;
    logic [DLY_W-1:0] dly;
  } dqps_loop_st_t;

  dqps_loop_st_t s_r;
  dqps_loop_st_t s_nxt;
  logic [LOCK_W-1:0] target;
  logic [DLY_W-1:0] dmax;

  // ==========================================================================
  // Lock timer and setting counter
  // The target follows the jitter mode; short modes cap the count at 31.
  assign target = low_jitter ? LOCK_LJ_CYC : LOCK_STD_CYC;
  assign dmax = dqps_mode_short(mode) ? DLY_MAX_SHORT : DLY_MAX_FULL;

  // Steps every cycle while locking, then only on update ticks.
  always_comb begin
    s_nxt = s_r;
    if ((s_r.st == LS_LOCKING) || upd_tick) begin
      if (upndn && (s_r.bin < dmax)) begin
        s_nxt.bin = s_r.bin + 6'h01;
      end else if (!upndn && (s_r.bin != 6'h00)) begin
        s_nxt.bin = s_r.bin - 6'h01;
      end
    end
    case (s_r.st)
      LS_LOCKING: begin
        s_nxt.cnt = s_r.cnt + 11'h001;
        if (s_r.cnt >= (target - 11'h001)) begin
          s_nxt.st = LS_LOCKED;
        end
      end
      LS_LOCKED: begin
        s_nxt.cnt = s_r.cnt;
      end
      default: begin
        s_nxt.st = LS_LOCKING;
      end
    endcase
    if (restart) begin
      s_nxt.st = LS_LOCKING;
      s_nxt.cnt = 11'h000;
      s_nxt.bin = 6'h00;
    end
    s_nxt.dly = dqps_bin2gray6(s_nxt.bin);
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign delay_gray = s_r.dly;
  assign locked = (s_r.st == LS_LOCKED);

  // ==========================================================================
  // Checks
  property p_gray_step;
    @(posedge hclk) disable iff (!hresetn)
      !$past(restart) |-> ($countones(delay_gray ^ $past(delay_gray)) <= 1);
  endproperty
  a_gray_step: assert property (p_gray_step) else $error("delay word moved more than one bit");

  property p_msb_zero;
    @(posedge hclk) disable iff (!hresetn)
      dqps_mode_short(mode) && $stable(mode) |=> (delay_gray[DLY_W-1] == 1'b0);
  endproperty
  a_msb_zero: assert property (p_msb_zero) else $error("msb set in a short mode");

  property p_lock_std;
    @(posedge hclk) disable iff (!hresetn)
      $rose(locked) && !$past(low_jitter) |-> ($past(s_r.cnt) == (LOCK_STD_CYC - 11'h001));
  endproperty
  a_lock_std: assert property (p_lock_std) else $error("standard lock count wrong");

  property p_lock_lj;
    @(posedge hclk) disable iff (!hresetn)
      $rose(locked) && $past(low_jitter) |-> ($past(s_r.cnt) == (LOCK_LJ_CYC - 11'h001));
  endproperty
  a_lock_lj: assert property (p_lock_lj) else $error("low jitter lock count wrong");

  property p_restart_unlock;
    @(posedge hclk) disable iff (!hresetn)
      restart |=> !locked ##1 !locked;
  endproperty
  a_restart_unlock: assert property (p_restart_unlock) else $error("lock held after restart");

  c_locked: cover property (@(posedge hclk) disable iff (!hresetn) $rose(locked));

endmodule

/* dv/dqps_cmp_model.sv */
/*
  Behavioural phase comparator facing both delay loops.
  Assumes the bench gives each loop a target delay in plain binary.
*/
module dqps_cmp_model
  import dqps_pkg::*;
(
  input wire logic hclk,
  input wire logic [NUM_LOOPS-1:0][DLY_W-1:0] dly_gray,
  input wire logic [NUM_LOOPS-1:0][DLY_W-1:0] target,
  output logic [NUM_LOOPS-1:0] upndn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DLY_W-1:0] bin;

  // ==========================================================================
  // Comparator
  // Ask for more delay while the decoded chain delay is below the target.
  always @(posedge hclk) begin
    for (int l = 0; l < NUM_LOOPS; l++) begin
      bin = dly_gray[l];
      for (int i = DLY_W - 2; i >= 0; i--) begin
        bin[i] = bin[i+1] ^ dly_gray[l][i];
      end
      upndn[l] <= (bin < target[l]);
    end
  end
endmodule

/* dv/test_dqps_top.sv */
/*
  Self-checking bench for the strobe phase-shift loop block.
  Assumes the comparator model in dqps_cmp_model and a single AHB-Lite slave.
*/
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_dqps_top;
  import dqps_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, loop_rst_pin = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, cqn_route_en;
  wire hready = hreadyout;
  logic [NUM_LOOPS-1:0] phase_upndn, loop_locked, lk_prev;
  logic [NUM_LOOPS-1:0][DLY_W-1:0] core_delay, tgt, dly_prev;
  logic [NUM_LOOPS-1:0][SEL_W-1:0] loop_ref_sel;
  logic [NUM_LOOPS-1:0][CHAIN_W-1:0] loop_chain_len;
  logic [NUM_LOOPS-1:0][NUM_SIDES-1:0][DLY_W-1:0] side_delay;
  logic [NUM_STROBES-1:0][DLY_W-1:0] pin_delay;
  logic [NUM_STROBES-1:0][OFS_W-1:0] pin_offset;
  logic [NUM_STROBES-1:0] pin_bypass, pin_core_route;
  int err_total = 0, n_checks = 0, n;
  logic [4:0] clen [6] = '{5'h10, 5'h0C, 5'h0A, 5'h08, 5'h0C, 5'h0A};

  dqps_top dqps_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .loop_rst_pin(loop_rst_pin),
    .phase_upndn(phase_upndn), .loop_ref_sel(loop_ref_sel), .loop_chain_len(loop_chain_len),
    .loop_locked(loop_locked), .core_delay(core_delay), .side_delay(side_delay),
    .pin_delay(pin_delay), .pin_offset(pin_offset), .pin_bypass(pin_bypass),
    .pin_core_route(pin_core_route), .cqn_route_en(cqn_route_en));
  dqps_cmp_model dqps_cmp_model_inst (.hclk(hclk), .dly_gray(core_delay), .target(tgt),
    .upndn(phase_upndn));

  // Clock of 100 ns period.
  always #50 hclk = ~hclk;

  // ==========================================================================
  // Monitor
  // Sides copy the core word a cycle later; locked steps flip one bit only.
  always @(posedge hclk) begin
    if (hresetn) begin
      for (int l = 0; l < NUM_LOOPS; l++) begin
        for (int s = 0; s < NUM_SIDES; s++) `CHK("side", dly_prev[l], side_delay[l][s])
        if (lk_prev[l] && loop_locked[l] && core_delay[l] != dly_prev[l])
          `CHK("gray", 1, $countones(core_delay[l] ^ dly_prev[l]))
      end
    end
    dly_prev = core_delay;
    lk_prev = loop_locked;
  end

  // ==========================================================================
  // Tasks
  // Ends the run with the counts and the verdict.
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Waits up to a bound for hready high at a rising edge.
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_total++;
      conclude();
    end
  endtask

  // One single AHB-Lite word transfer.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  // Counts edges until the loop reports lock, with a bound.
  task automatic wait_lock(input int l);
    n = 0;
    while (loop_locked[l] !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    // A loop that never locks ends the run as a failure.
    if (n >= 2000) begin
      err_total++;
      conclude();
    end
  endtask

  function automatic logic [6:0] g7(input logic [6:0] b);
    return b ^ (b >> 1);
  endfunction

  // ==========================================================================
  // Sequence
  initial begin
    tgt = {6'h00, 6'h28};
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    xfer(0, ADDR_CTRL0, 0);
    `CHK("ctrl_rst", 32'h8, rd)
    xfer(0, 8'h1C, 0);
    `CHK("unmapped", 32'h0, rd)
    wait_lock(0);
    `CHK("lock_lj", 1, n >= 1270 && n <= 1281)
    `CHK("msb_full", 1'b1, core_delay[0][5])
    xfer(1, ADDR_CTRL0, 32'h4);
    repeat (2) @(posedge hclk);
    `CHK("restart", 1'b0, loop_locked[0])
    wait_lock(0);
    `CHK("lock_std", 1, n >= 250 && n <= 258)
    repeat (20) @(posedge hclk);
    `CHK("sat_short", 6'h10, core_delay[0])
    xfer(0, ADDR_STATUS, 0);
    `CHK("status", 32'h1003, rd)
    xfer(1, ADDR_OFS0, {16'h0, 1'b0, g7(7'h28), 1'b0, g7(7'h7B)});
    xfer(1, ADDR_PINSEL, 32'h8);
    xfer(1, ADDR_ROUTE, 32'h18280);
    repeat (8) @(posedge hclk);
    `CHK("ofs_a", g7(7'h7B), pin_offset[0])
    `CHK("ofs_clamp", g7(7'h1F), pin_offset[1])
    `CHK("pin_dly", {6'h10, 6'h10}, {pin_delay[1], pin_delay[0]})
    `CHK("bypass", 8'h80, pin_bypass)
    `CHK("byp_dly", 13'h0, {pin_delay[7], pin_offset[7]})
    `CHK("core_route", 8'h02, pin_core_route)
    `CHK("cqn", 1'b1, cqn_route_en)
    for (int m = 0; m < 6; m++) begin
      xfer(1, ADDR_CTRL1, 32'h8 | m);
      repeat (2) @(posedge hclk);
      `CHK("chain", clen[m], loop_chain_len[1])
    end
    xfer(1, ADDR_CTRL1, 32'h0E);
    repeat (2) @(posedge hclk);
    `CHK("mode_bad", 5'h0A, loop_chain_len[1])
    xfer(1, ADDR_CTRL1, 32'h808);
    @(posedge hclk);
    `CHK("ref_pin", 4'h8, loop_ref_sel[1])
    xfer(1, ADDR_CTRL1, 32'h908);
    @(posedge hclk);
    `CHK("ref_bad", 4'h0, loop_ref_sel[1])
    wait_lock(1);
    loop_rst_pin <= 1;
    repeat (5) @(posedge hclk);
    `CHK("pin_rst", 2'b00, loop_locked)
    loop_rst_pin <= 0;
    wait_lock(0);
    `CHK("relock", 1, n >= 250 && n <= 262)
    wait_lock(1);
    `CHK("relock1", 1'b1, loop_locked[1])
    xfer(1, ADDR_ROUTE, 32'h101);
    repeat (8) @(posedge hclk);
    `CHK("byp0", 15'h4000, {pin_bypass[0], pin_core_route[0], pin_delay[0], pin_offset[0]})
    conclude();
  end
endmodule
